//--- core/stt_defs.svh
`ifndef STT_DEFS_SVH
`define STT_DEFS_SVH

// register offsets
`define STT_CTRL_OFS 8'h10
`define STT_RELOAD_OFS 8'h14
`define STT_COUNT_OFS 8'h18
`define STT_CALIB_OFS 8'h1c
`define STT_PRIO_OFS 8'h20
// control and priority field positions
`define STT_EN_BIT 0
`define STT_IRQ_BIT 1
`define STT_SRC_BIT 2
`define STT_FLAG_BIT 16
`define STT_PRIO_LSB 30
// reset values
`define STT_CTRL_RST 3'h0
`define STT_PRIO_RST 2'h0
// calibration timing
`define STT_TEN_MS_NS 10000000
`define STT_CLK_NS 10
`endif

//--- core/stt_pkg.sv
package stt_pkg;
  typedef enum logic [1:0] {
    STT_IDLE = 2'h0,
    STT_RUN = 2'h1,
    STT_STOP = 2'h3
  } stt_mode_e;

  // register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } stt_req_s;

  typedef struct packed {
    stt_mode_e mode;
    logic [23:0] count;
    logic [23:0] reload;
    logic enable;
    logic irq_en;
    logic src_sel;
    logic flag;
    logic [1:0] prio;
    logic [31:0] rdata;
    logic pend;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
  } stt_state_s;
endpackage

//--- core/stt_timer.sv
`timescale 1ns/1ps
`include "stt_defs.svh"
module stt_timer #(
  parameter int CNT_W = 24,
  parameter bit HAS_EXT_REF = 1'b1,
  parameter logic [23:0] CALIB_VALUE = 24'(`STT_TEN_MS_NS / `STT_CLK_NS - 1)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // system side
  input wire logic debug_halt,
  input wire logic ext_ref_clk,
  output logic tick_pend,
  output logic [1:0] tick_handler_priority
);

  stt_pkg::stt_req_s req;
  stt_pkg::stt_state_s st_reg;
  stt_pkg::stt_state_s st_next;
  logic tick;
  logic ctrl_hit;
  logic zero_hit;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // reference edge: rising edge of synchronised external clock or every cycle
  always_comb begin
    if (st_reg.src_sel || !HAS_EXT_REF) begin
      tick = 1'b1;
    end else begin
      tick = st_reg.ref_s2 && !st_reg.ref_s3;
    end
  end

  assign ctrl_hit = hit(req.addr, `STT_CTRL_OFS);

  // next state
  always_comb begin
    st_next = st_reg;
    st_next.pend = 1'b0;
    zero_hit = 1'b0;
    // two-stage synchroniser, third stage for edge detect only
    st_next.ref_s1 = ext_ref_clk;
    st_next.ref_s2 = st_reg.ref_s1;
    st_next.ref_s3 = st_reg.ref_s2;

    // counting; frozen while halted in debug
    if (st_reg.enable && tick && !debug_halt) begin
      if (st_reg.count == '0) begin
        st_next.count = st_reg.reload;
        st_next.mode = (st_reg.reload == '0) ? stt_pkg::STT_STOP : stt_pkg::STT_RUN;
      end else begin
        st_next.count = st_reg.count - 24'h1;
        st_next.mode = stt_pkg::STT_RUN;
        if (st_reg.count == 24'h1) begin
          st_next.flag = 1'b1;
          zero_hit = 1'b1;
          st_next.pend = st_reg.irq_en;
        end
      end
    end

    // a control read clears the flag, but a fresh wrap in the same cycle wins
    if (req.rd && ctrl_hit && !zero_hit) begin
      st_next.flag = 1'b0;
    end

    // writes
    if (req.wr) begin
      case (1'b1)
        hit(req.addr, `STT_CTRL_OFS): begin
          st_next.enable = req.wdata[`STT_EN_BIT];
          st_next.irq_en = req.wdata[`STT_IRQ_BIT];
          st_next.src_sel = HAS_EXT_REF ? req.wdata[`STT_SRC_BIT] : 1'b1;
        end
        hit(req.addr, `STT_RELOAD_OFS): begin
          st_next.reload = req.wdata[23:0];
        end
        hit(req.addr, `STT_COUNT_OFS): begin
          // clear only; no exception raised by this path
          st_next.count = '0;
          st_next.flag = 1'b0;
          st_next.pend = 1'b0;
          st_next.mode = stt_pkg::STT_IDLE;
        end
        hit(req.addr, `STT_PRIO_OFS): begin
          st_next.prio = req.wdata[31:`STT_PRIO_LSB];
        end
        default: begin
        end
      endcase
    end

    // read data, one cycle later; unmapped reads zero
    st_next.rdata = 32'h0;
    if (req.rd) begin
      case (1'b1)
        ctrl_hit: begin
          st_next.rdata[`STT_FLAG_BIT] = st_reg.flag;
          st_next.rdata[`STT_SRC_BIT] = st_reg.src_sel;
          st_next.rdata[`STT_IRQ_BIT] = st_reg.irq_en;
          st_next.rdata[`STT_EN_BIT] = st_reg.enable;
        end
        hit(req.addr, `STT_RELOAD_OFS): st_next.rdata = {8'h0, st_reg.reload};
        hit(req.addr, `STT_COUNT_OFS): st_next.rdata = {8'h0, st_reg.count};
        hit(req.addr, `STT_CALIB_OFS): st_next.rdata = {8'h0, CALIB_VALUE};
        hit(req.addr, `STT_PRIO_OFS): st_next.rdata = {st_reg.prio, 30'h0};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  // state register; count and reload start at zero, software reprograms them
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.src_sel <= !HAS_EXT_REF;
      st_reg.prio <= `STT_PRIO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign tick_pend = st_reg.pend;
  assign tick_handler_priority = st_reg.prio;

  // checks; the helpers below feed only the assertions
  logic wr_count;
  logic any_hit;
  logic src_wbit;
  logic [1:0] ctrl_wdata;
  logic [1:0] prio_wdata;
  logic [23:0] reload_wdata;

  // slices taken once so that $past sees plain signals
  assign wr_count = wr && hit(addr, `STT_COUNT_OFS);
  assign any_hit = ctrl_hit || hit(addr, `STT_RELOAD_OFS) || hit(addr, `STT_COUNT_OFS) ||
    hit(addr, `STT_CALIB_OFS) || hit(addr, `STT_PRIO_OFS);
  assign src_wbit = wdata[`STT_SRC_BIT];
  assign ctrl_wdata = wdata[1:0];
  assign prio_wdata = wdata[31:30];
  assign reload_wdata = wdata[23:0];

  // a tick at zero reloads; a count write in that cycle wins instead
  wrap_reload_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.enable && tick && !debug_halt && st_reg.count == '0 && !wr_count
    |=> st_reg.count == $past(st_reg.reload))
    else $error("no reload after zero");

  // count write also lands on zero, but clears the flag, so it is excluded
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st_reg.count == '0) && !$past(wr) |-> st_reg.flag)
    else $error("flag missing on zero");

  // wrap in the read cycle excluded: set beats clear
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && ctrl_hit && !(st_reg.count == 24'h1 && st_reg.enable) |=> !st_reg.flag)
    else $error("flag not cleared by read");

  // count write clears count and flag together
  count_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_count |=> st_reg.count == '0 && !st_reg.flag)
    else $error("count write");

  // forcing zero by software must never look like a wrap to the exception side
  no_pend_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_count |=> !tick_pend)
    else $error("pend on count write");

  // read returns the count as it stood in the access cycle
  count_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && hit(addr, `STT_COUNT_OFS) |=> rdata == {8'h0, $past(st_reg.count)})
    else $error("bad count read");

  // debug halt freezes the count; only a count write moves it
  halt_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    debug_halt && !wr |=> $stable(st_reg.count))
    else $error("count moved in halt");

  // a pend only follows a 1 to 0 step with interrupts enabled
  pend_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick_pend |-> $past(st_reg.irq_en) && st_reg.count == $past(st_reg.count) - 24'h1 && st_reg.count == '0)
    else $error("pend without wrap");

  // calibration is a constant of the build
  calib_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && hit(addr, `STT_CALIB_OFS) |=> rdata == {8'h0, CALIB_VALUE})
    else $error("bad calibration");

  // read data must be zero outside the answer cycle, so the bus can or-combine slaves
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !rd |=> rdata == 32'h0)
    else $error("read data outside answer");

  // control read shows every field in place
  ctrl_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && ctrl_hit |=> rdata[`STT_FLAG_BIT] == $past(st_reg.flag) &&
    rdata[2:0] == {$past(st_reg.src_sel), $past(st_reg.irq_en), $past(st_reg.enable)})
    else $error("bad control read");

  // reserved control bits read zero
  ctrl_rsvd_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && ctrl_hit |=> rdata[31:17] == 15'h0 && rdata[15:3] == 13'h0)
    else $error("control reserved bits set");

  // reload reads back as written, upper byte zero
  reload_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && hit(addr, `STT_RELOAD_OFS) |=> rdata == {8'h0, $past(st_reg.reload)})
    else $error("bad reload read");

  // all 24-bit registers keep their top byte clear
  upper_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && (hit(addr, `STT_COUNT_OFS) || hit(addr, `STT_RELOAD_OFS) || hit(addr, `STT_CALIB_OFS))
    |=> rdata[31:24] == 8'h0)
    else $error("upper byte not zero");

  // priority field sits in the top two bits only
  prio_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rd && hit(addr, `STT_PRIO_OFS) |=> rdata == {$past(st_reg.prio), 30'h0})
    else $error("bad priority read");

  // priority pins follow a write one cycle later
  prio_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr && hit(addr, `STT_PRIO_OFS) |=> tick_handler_priority == $past(prio_wdata))
    else $error("priority not written");

  // priority stands until written again
  prio_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(wr && hit(addr, `STT_PRIO_OFS)) |=> $stable(tick_handler_priority))
    else $error("priority changed unasked");

  // reload takes only the low 24 bits of a write
  reload_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr && hit(addr, `STT_RELOAD_OFS) |=> st_reg.reload == $past(reload_wdata))
    else $error("reload not written");

  // reload never moves on its own
  reload_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(wr && hit(addr, `STT_RELOAD_OFS)) |=> $stable(st_reg.reload))
    else $error("reload changed unasked");

  // enable and interrupt enable bits follow a control write
  ctrl_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr && ctrl_hit |=> {st_reg.irq_en, st_reg.enable} == $past(ctrl_wdata))
    else $error("control not written");

  // without an external reference the source bit is pinned to one
  src_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr && ctrl_hit |=> st_reg.src_sel == (HAS_EXT_REF ? $past(src_wbit) : 1'b1))
    else $error("source bit wrong");

  // a disabled counter stands still
  disabled_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_reg.enable && !wr_count |=> $stable(st_reg.count))
    else $error("count moved while disabled");

  // one step down per tick away from zero
  decrement_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.enable && tick && !debug_halt && st_reg.count != '0 && !wr_count
    |=> st_reg.count == $past(st_reg.count) - 24'h1)
    else $error("no decrement on tick");

  // no reference edge, no count
  no_tick_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !tick && !wr_count |=> $stable(st_reg.count))
    else $error("count moved without tick");

  // zero reload parks the counter whatever the enable bit says
  park_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.count == '0 && st_reg.reload == '0 |=> st_reg.count == '0)
    else $error("count left park");

  // parking is visible in the mode
  park_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.enable && tick && !debug_halt && st_reg.count == '0 && st_reg.reload == '0 && !wr_count
    |=> st_reg.mode == stt_pkg::STT_STOP)
    else $error("park mode missing");

  // the flag only rises on a 1 to 0 step
  flag_origin_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st_reg.flag) |-> $past(st_reg.count) == 24'h1 && st_reg.count == '0)
    else $error("flag rose without wrap");

  // sticky: only a control read or count write drops it
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.flag && !(rd && ctrl_hit) && !wr_count |=> st_reg.flag)
    else $error("flag dropped unasked");

  // pend is a single-cycle request, even with reload of one
  pend_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick_pend |=> !tick_pend)
    else $error("pend longer than a cycle");

  // interrupt enable off means no request at all
  irq_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_reg.irq_en |=> !tick_pend)
    else $error("pend with irq disabled");

  // every wrap with interrupts on raises the request, unless a count write lands in the same cycle
  pend_on_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    zero_hit && st_reg.irq_en && !wr_count |=> tick_pend)
    else $error("wrap without pend");

  // every wrap sets the flag, even against a control read, but not against a count write in the same cycle
  flag_on_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    zero_hit && !wr_count |=> st_reg.flag)
    else $error("wrap without flag");

  // a frozen counter cannot wrap
  halt_no_pend_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    debug_halt |=> !tick_pend)
    else $error("pend during halt");

  // second synchroniser stage lags the pin by exactly two edges
  sync_chain_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.ref_s2 == $past(ext_ref_clk, 2))
    else $error("synchroniser lag wrong");

  // after a count write the next tick loads the reload value
  clear_reload_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_count ##1 (st_reg.enable && tick && !debug_halt && !wr_count)
    |=> st_reg.count == $past(st_reg.reload))
    else $error("no reload after count write");

  // writes to unmapped offsets touch nothing
  unmapped_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr && !any_hit |=> $stable(st_reg.reload) && $stable(tick_handler_priority) &&
    st_reg.irq_en == $past(st_reg.irq_en))
    else $error("unmapped write had effect");

  // main scenarios
  c_wrap: cover property (@(posedge clk_sys) disable iff (!nrst) tick_pend);
  c_stop: cover property (@(posedge clk_sys) disable iff (!nrst) st_reg.mode == stt_pkg::STT_STOP);
  c_halt: cover property (@(posedge clk_sys) disable iff (!nrst) debug_halt && st_reg.enable);
  c_read_clear: cover property (@(posedge clk_sys) disable iff (!nrst) rd && ctrl_hit && st_reg.flag);
  c_ext_tick: cover property (@(posedge clk_sys) disable iff (!nrst) !st_reg.src_sel && tick && st_reg.enable);
endmodule

//--- tb/stt_partner.sv
`timescale 1ns/1ps
module stt_partner (
  // timer side
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic tick_pend,
  // reference and exception side
  output logic ext_ref_clk,
  output int pend_cnt
);
  logic [1:0] div_reg;
  // slow reference, eight cycles a period
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 2'h0;
      ext_ref_clk <= 1'b0;
      pend_cnt <= 0;
    end else begin
      div_reg <= div_reg + 2'h1;
      ext_ref_clk <= (div_reg == 2'h3) ? ~ext_ref_clk : ext_ref_clk;
      pend_cnt <= pend_cnt + int'(tick_pend);
    end
  end
endmodule

//--- tb/stt_timer_test.sv
`timescale 1ns/1ps
module stt_timer_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic debug_halt = 1'b0;
  logic [31:0] rdata, v, w;
  logic tick_pend, ext_ref_clk;
  logic [1:0] prio;
  int pend_cnt, n;
  int error_cnt = 0;
  int cmp_count = 0;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  stt_timer u_dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .debug_halt(debug_halt), .ext_ref_clk(ext_ref_clk), .tick_pend(tick_pend),
    .tick_handler_priority(prio));
  stt_partner u_far (.clk_sys(clk_sys), .nrst(nrst), .tick_pend(tick_pend),
    .ext_ref_clk(ext_ref_clk), .pend_cnt(pend_cnt));
  // one-cycle strobes, changed just after the edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog at 20000 cycles, well beyond the 160 or so cycles of the tests
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_reg(8'h10, v);
    chk("ctrl", 32'h0, v);
    rd_reg(8'h1c, v);
    chk("calib", 32'd999999, v);
    rd_reg(8'h40, v);
    chk("unmapped", 32'h0, v);
    wr_reg(8'h20, 32'hffffffff);
    rd_reg(8'h20, v);
    chk("prio", 32'hc0000000, v);
    chk("prio_pin", 32'h3, {30'h0, prio});
    $display("test regs done");
    // software order: reload, clear count, then enable
    wr_reg(8'h14, 32'hff000005);
    wr_reg(8'h18, 32'h0);
    wr_reg(8'h10, 32'h7);
    for (n = 0; n < 100 && pend_cnt == 0; n++) @(posedge clk_sys);
    chk("pended", 32'h1, {31'h0, pend_cnt > 0});
    wr_reg(8'h10, 32'h6);
    rd_reg(8'h14, v);
    chk("reload", 32'h5, v);
    rd_reg(8'h10, v);
    chk("flag_set", 32'h10006, v);
    rd_reg(8'h10, v);
    chk("flag_clr", 32'h6, v);
    $display("test wrap done");
    wr_reg(8'h14, 32'hffff);
    wr_reg(8'h10, 32'h7);
    n = pend_cnt;
    wr_reg(8'h18, 32'h12345678);
    repeat (5) @(posedge clk_sys);
    chk("no_pend", 32'(n), 32'(pend_cnt));
    rd_reg(8'h18, v);
    chk("reloaded", 32'h1, {31'h0, v > 32'hff00 && v <= 32'hffff});
    rd_reg(8'h10, v);
    chk("flag_wr", 32'h7, v);
    @(posedge clk_sys);
    debug_halt <= 1'b1;
    rd_reg(8'h18, v);
    repeat (10) @(posedge clk_sys);
    rd_reg(8'h18, w);
    chk("halted", v, w);
    @(posedge clk_sys);
    debug_halt <= 1'b0;
    rd_reg(8'h18, v);
    rd_reg(8'h18, w);
    chk("live", v - 32'h2, w);
    $display("test count done");
    wr_reg(8'h10, 32'h3);
    rd_reg(8'h18, v);
    repeat (40) @(posedge clk_sys);
    rd_reg(8'h18, w);
    chk("ext_ref", 32'h1, {31'h0, w < v && w + 32'h10 > v});
    // run a short period, then zero the reload while counting
    wr_reg(8'h10, 32'h7);
    n = pend_cnt;
    wr_reg(8'h14, 32'h3);
    wr_reg(8'h18, 32'h0);
    wr_reg(8'h14, 32'h0);
    repeat (10) @(posedge clk_sys);
    rd_reg(8'h18, v);
    chk("parked", 32'h0, v);
    rd_reg(8'h10, v);
    chk("park_flag", 32'h10007, v);
    chk("park_pend", 32'(n + 1), 32'(pend_cnt));
    rd_reg(8'h18, v);
    chk("still_parked", 32'h0, v);
    $display("test source and park done");
    end_sim();
  end
endmodule
